// *** logic/epc_pkg.sv ***
/*
  Shared constants for the external bus pin control block: register indices,
  field positions, reset values, bus phase timing and the mode and cycle types.
  Assumes a register bus with 32-bit words; byte address is four times the index.
*/
package epc_pkg;

  // Register indices (byte address is index times four)
  localparam logic [13:0] IDX_PORT_A_DATA  = 14'h1000;
  localparam logic [13:0] IDX_PORT_A_DIR   = 14'h1001;
  localparam logic [13:0] IDX_PORT_G_DATA  = 14'h1002;
  localparam logic [13:0] IDX_PORT_G_DIR   = 14'h1003;
  localparam logic [13:0] IDX_PORT_B_DATA  = 14'h1004;
  localparam logic [13:0] IDX_PORT_F_DATA  = 14'h1005;
  localparam logic [13:0] IDX_PORT_C_DATA  = 14'h1006;
  localparam logic [13:0] IDX_PORT_C_DIR   = 14'h1007;
  localparam logic [13:0] IDX_PORT_D_DATA  = 14'h1008;
  localparam logic [13:0] IDX_PORT_D_DIR   = 14'h1009;
  localparam logic [13:0] IDX_PORT_E_DATA  = 14'h100A;
  localparam logic [13:0] IDX_SEL_STRETCH  = 14'h105C;
  localparam logic [13:0] IDX_SEL_CONTROL  = 14'h105D;
  localparam logic [13:0] IDX_SEL_BASE     = 14'h105E;
  localparam logic [13:0] IDX_SEL_SIZE     = 14'h105F;
  localparam logic [13:0] IDX_STATUS       = 14'h1060;
  localparam logic [13:0] IDX_EXT_ADDR     = 14'h1061;
  localparam logic [13:0] IDX_EXT_DATA     = 14'h1062;
  localparam logic [13:0] IDX_EXT_CTRL     = 14'h1063;
  localparam logic [13:0] IDX_INT_MASK     = 14'h1064;

  // Field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_WRITE_BIT  = 1;
  localparam int SEL_ENABLE_BIT  = 2;
  localparam int MASK_IRQ_BIT    = 0;
  localparam int MASK_NONMASKABLE_INTERRUPT_IN_BIT   = 1;
  localparam int PORT_D_WIDTH    = 6;

  // Reset values
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;
  localparam logic [1:0]  MASK_RESET     = 2'h3;

  // Bus phase timing in oscillator cycles; mode latch delay in system clock cycles
  localparam int          OSC_PER_BUS    = 4;
  localparam logic [2:0]  LOW_TICKS      = 3'h2;
  localparam logic [2:0]  HIGH_TICKS     = 3'h2;
  localparam logic [2:0]  STRETCH_TICKS  = 3'h4;
  localparam logic [2:0]  LAST_TICK      = 3'h1;
  localparam logic [1:0]  LATCH_DELAY    = 2'h2;

  // Operating mode, coded as {second select, first select}
  typedef enum logic [1:0] {
    EPC_MODE_BOOT,
    EPC_MODE_TEST,
    EPC_MODE_SINGLE,
    EPC_MODE_EXPANDED
  } epc_mode_t;

  // External bus cycle phases
  typedef enum logic [1:0] {
    EPC_CYC_IDLE,
    EPC_CYC_ADDR,
    EPC_CYC_DATA
  } epc_cycle_t;

endpackage

// *** logic/epc_eclk.sv ***
/*
  Bus phase clock generator. Counts oscillator ticks: two low, two high,
  or four high when the stretch request is high at the rising edge.
  Assumes osc_tick_i is a one-cycle pulse per oscillator rising edge and
  wait_i is already synchronised.
*/
`timescale 1ns/1ps
module epc_eclk (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Timing inputs
  input  wire logic osc_tick_i,
  input  wire logic wait_i,
  // Next phase clock level and its edges
  output logic      e_nxt_o,
  output logic      e_rise_o,
  output logic      e_fall_o
);

  logic       e_r;
  logic [2:0] cnt_r;
  logic       edge_now;

  // A change of level is due on this tick
  assign edge_now = osc_tick_i && (cnt_r == epc_pkg::LAST_TICK);
  assign e_nxt_o  = edge_now ? ~e_r : e_r;
  assign e_rise_o = edge_now && !e_r;
  assign e_fall_o = edge_now && e_r;

  // Phase counter; stretch request sampled at each rising edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e_r   <= 1'b0;
      cnt_r <= epc_pkg::LOW_TICKS;
    end else if (edge_now) begin
      e_r <= ~e_r;
      if (!e_r) begin
        cnt_r <= wait_i ? epc_pkg::STRETCH_TICKS : epc_pkg::HIGH_TICKS;
      end else begin
        cnt_r <= epc_pkg::LOW_TICKS;
      end
    end else if (osc_tick_i) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

endmodule

// *** logic/epc_top.sv ***
/*
  External bus pin control: phase clock and strobe, stretch, mode latch,
  reset failure drive, interrupt inputs, instruction start mark and the
  port pins, with registers over AHB-Lite.
  Assumes one system clock faster than twice the oscillator pin rate;
  bidirectional pins are split into input, output and active-low output enable.
*/
// How it works
// - Reset puts every register and pin control into a fixed startup state.
// - Clock monitor or watchdog failure pulls the reset pin low, open drain.
// - Bus phase clock is the oscillator input divided by four.
// - Address is driven while phase clock low; data bus used only while high.
// - Bus strobe output is always the inverse of the phase clock.
// - Stretch request is sampled at every rising edge of the phase clock.
// - Stretch high keeps the phase clock high for four oscillator cycles.
// - Stretch low lets the phase clock fall two oscillator cycles after rising.
// - A buffered copy of the oscillator appears on its own output.
// - Low maskable interrupt pin raises a maskable request to the processor.
// - Second interrupt input becomes non-maskable once its mask bit is cleared.
// - Mode select pins are latched at reset to pick the operating mode.
// - After reset the first mode pin drives instruction start, open drain.
// - Expanded and test modes drive the read or write direction output.
// - Port A pins are all inputs after reset.
// - Port B is output only: general outputs, or high address byte expanded.
// - Port C is direction-controlled I/O, or the data bus when expanded.
// - Port D has six lines, general I/O or taken over by serial logic.
// - Port F is output only: general outputs, or low address byte expanded.
// - Enabled chip selects replace general use of port G upper four pins.
`timescale 1ns/1ps
module epc_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [15:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Oscillator and bus timing pins
  input  wire logic        oscillator_input_i,
  output logic             buffered_osc_out_o,
  output logic             e_clock_o,
  output logic             inverted_bus_strobe_o,
  input  wire logic        wait_i,
  output logic             read_write_o,
  // Reset pin open-drain drive and failure sources
  output logic             reset_pin_oe_n_o,
  input  wire logic        clock_monitor_fail_i,
  input  wire logic        watchdog_timer_fail_i,
  // Interrupt pins and requests
  input  wire logic        irq_n_i,
  input  wire logic        nonmaskable_interrupt_in_n_i,
  output logic             irq_req_o,
  output logic             nmi_req_o,
  // Mode pins and instruction start
  input  wire logic        mode_select_first_i,
  input  wire logic        mode_select_second_i,
  output logic             instruction_start_out_o,
  output logic             instruction_start_oe_n_o,
  input  wire logic        instr_start_i,
  output logic [1:0]       mode_o,
  // Port A
  input  wire logic [7:0]  port_a_pins_i,
  output logic [7:0]       port_a_pins_o,
  output logic [7:0]       port_a_pins_oe_n_o,
  // Ports B and F
  output logic [7:0]       port_b_pins_o,
  output logic [7:0]       port_f_pins_o,
  // Port C
  input  wire logic [7:0]  port_c_pins_i,
  output logic [7:0]       port_c_pins_o,
  output logic [7:0]       port_c_pins_oe_n_o,
  // Port D and serial takeover
  input  wire logic [5:0]  port_d_pins_i,
  output logic [5:0]       port_d_pins_o,
  output logic [5:0]       port_d_pins_oe_n_o,
  input  wire logic [5:0]  serial_take_i,
  input  wire logic [5:0]  serial_out_i,
  input  wire logic [5:0]  serial_drive_i,
  // Port E
  input  wire logic [7:0]  input_port_e_data_i,
  // Port G and chip selects
  input  wire logic [7:0]  port_g_pins_i,
  output logic [7:0]       port_g_pins_o,
  output logic [7:0]       port_g_pins_oe_n_o,
  input  wire logic [3:0]  chip_select_i
);

  localparam int SYNC_W = 44;

  logic              rst_s1_r;
  logic              rst_n;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              osc_s;
  logic              osc_prev_r;
  logic              osc_tick;
  logic              wait_s;
  logic              irq_n_s;
  logic              nmi_n_s;
  logic              mode_a_s;
  logic              mode_b_s;
  logic [7:0]        pa_s;
  logic [7:0]        pc_s;
  logic [5:0]        pd_s;
  logic [7:0]        pg_s;
  logic [7:0]        pe_s;
  logic              e_nxt;
  logic              e_rise;
  logic              e_fall;
  logic              wr_pend_r;
  logic [13:0]       wr_idx_r;
  logic              acc_ok;
  logic [13:0]       acc_idx;
  logic [7:0]        dir_a_r;
  logic [7:0]        dir_g_r;
  logic [7:0]        dir_c_r;
  logic [5:0]        dir_d_r;
  logic [7:0]        out_a_r;
  logic [7:0]        out_g_r;
  logic [7:0]        out_b_r;
  logic [7:0]        out_f_r;
  logic [7:0]        out_c_r;
  logic [5:0]        out_d_r;
  logic [7:0]        sel_stretch_r;
  logic [7:0]        sel_control_r;
  logic [7:0]        sel_base_r;
  logic [7:0]        sel_size_r;
  logic [15:0]       ext_addr_r;
  logic [7:0]        ext_wdata_r;
  logic [7:0]        ext_rdata_r;
  logic              ext_write_r;
  logic              ext_pend_r;
  logic [1:0]        int_mask_r;
  logic [1:0]        latch_cnt_r;
  logic              latched_r;
  epc_pkg::epc_mode_t  mode_r;
  epc_pkg::epc_cycle_t cyc_r;
  epc_pkg::epc_cycle_t cyc_nxt;
  logic              expanded;
  logic              start_req;
  logic [31:0]       rd_val;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Two-stage synchroniser for every pin input
  assign sync_in = {oscillator_input_i, wait_i, irq_n_i, nonmaskable_interrupt_in_n_i,
                    mode_select_first_i, mode_select_second_i, port_a_pins_i, port_c_pins_i,
                    port_d_pins_i, port_g_pins_i, input_port_e_data_i};
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end
  assign {osc_s, wait_s, irq_n_s, nmi_n_s, mode_a_s, mode_b_s, pa_s, pc_s, pd_s, pg_s, pe_s} = sync2_r;

  // Oscillator rising edge tick and buffered copy
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_r         <= 1'b0;
      buffered_osc_out_o <= 1'b0;
    end else begin
      osc_prev_r         <= osc_s;
      buffered_osc_out_o <= osc_s;
    end
  end
  assign osc_tick = osc_s && !osc_prev_r;

  // Phase clock generator
  epc_eclk u_eclk (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n),
    .osc_tick_i (osc_tick),
    .wait_i     (wait_s),
    .e_nxt_o    (e_nxt),
    .e_rise_o   (e_rise),
    .e_fall_o   (e_fall)
  );

  // Phase clock and strobe pins
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      e_clock_o             <= 1'b0;
      inverted_bus_strobe_o <= 1'b1;
    end else begin
      e_clock_o             <= e_nxt;
      inverted_bus_strobe_o <= ~e_nxt;
    end
  end

  // Mode pins caught once the synchroniser has settled after release
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      latch_cnt_r <= 2'h0;
      latched_r   <= 1'b0;
      mode_r      <= epc_pkg::EPC_MODE_BOOT;
    end else if (!latched_r) begin
      if (latch_cnt_r == epc_pkg::LATCH_DELAY) begin
        latched_r <= 1'b1;
        mode_r    <= epc_pkg::epc_mode_t'({mode_b_s, mode_a_s});
      end else begin
        latch_cnt_r <= latch_cnt_r + 2'h1;
      end
    end
  end
  assign expanded = mode_r[0];
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_o <= 2'h0;
    end else begin
      mode_o <= mode_r;
    end
  end

  // Reset pin failure drive, instruction start mark and interrupt requests
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_oe_n_o         <= 1'b1;
      instruction_start_out_o  <= 1'b0;
      instruction_start_oe_n_o <= 1'b1;
      irq_req_o                <= 1'b0;
      nmi_req_o                <= 1'b0;
    end else begin
      reset_pin_oe_n_o         <= ~(clock_monitor_fail_i | watchdog_timer_fail_i);
      instruction_start_out_o  <= 1'b0;
      instruction_start_oe_n_o <= ~(latched_r && instr_start_i);
      irq_req_o                <= ~irq_n_s && !int_mask_r[epc_pkg::MASK_IRQ_BIT];
      nmi_req_o                <= ~nmi_n_s && !int_mask_r[epc_pkg::MASK_NONMASKABLE_INTERRUPT_IN_BIT];
    end
  end

  // AHB-Lite address phase capture; zero wait, always OKAY
  assign acc_ok  = hsel_i && hready_i && htrans_i[1];
  assign acc_idx = haddr_i[15:2];
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r   <= 1'b0;
      wr_idx_r    <= 14'h0000;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r   <= acc_ok && hwrite_i;
      wr_idx_r    <= acc_idx;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (acc_ok && !hwrite_i) begin
        hrdata_o <= rd_val;
      end
    end
  end

  // Read mux; input pins read their level, output pins their latch
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (acc_idx)
      epc_pkg::IDX_PORT_A_DATA: rd_val[7:0] = (dir_a_r & out_a_r) | (~dir_a_r & pa_s);
      epc_pkg::IDX_PORT_A_DIR:  rd_val[7:0] = dir_a_r;
      epc_pkg::IDX_PORT_G_DATA: rd_val[7:0] = (dir_g_r & out_g_r) | (~dir_g_r & pg_s);
      epc_pkg::IDX_PORT_G_DIR:  rd_val[7:0] = dir_g_r;
      epc_pkg::IDX_PORT_B_DATA: rd_val[7:0] = out_b_r;
      epc_pkg::IDX_PORT_F_DATA: rd_val[7:0] = out_f_r;
      epc_pkg::IDX_PORT_C_DATA: rd_val[7:0] = (dir_c_r & out_c_r) | (~dir_c_r & pc_s);
      epc_pkg::IDX_PORT_C_DIR:  rd_val[7:0] = dir_c_r;
      epc_pkg::IDX_PORT_D_DATA: rd_val[5:0] = (dir_d_r & out_d_r) | (~dir_d_r & pd_s);
      epc_pkg::IDX_PORT_D_DIR:  rd_val[5:0] = dir_d_r;
      epc_pkg::IDX_PORT_E_DATA: rd_val[7:0] = pe_s;
      epc_pkg::IDX_SEL_STRETCH: rd_val[7:0] = sel_stretch_r;
      epc_pkg::IDX_SEL_CONTROL: rd_val[7:0] = sel_control_r;
      epc_pkg::IDX_SEL_BASE:    rd_val[7:0] = sel_base_r;
      epc_pkg::IDX_SEL_SIZE:    rd_val[7:0] = sel_size_r;
      epc_pkg::IDX_STATUS:      rd_val[5:0] = {nmi_req_o, irq_req_o, latched_r, mode_r, ext_pend_r || (cyc_r != epc_pkg::EPC_CYC_IDLE)};
      epc_pkg::IDX_EXT_ADDR:    rd_val[15:0] = ext_addr_r;
      epc_pkg::IDX_EXT_DATA:    rd_val[7:0] = ext_rdata_r;
      epc_pkg::IDX_EXT_CTRL:    rd_val[1:0] = {ext_write_r, ext_pend_r};
      epc_pkg::IDX_INT_MASK:    rd_val[1:0] = int_mask_r;
      default:                  rd_val = 32'h0000_0000;
    endcase
  end

  // Register writes in the data phase
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_a_r       <= epc_pkg::DIR_RESET;
      dir_g_r       <= epc_pkg::DIR_RESET;
      dir_c_r       <= epc_pkg::DIR_RESET;
      dir_d_r       <= epc_pkg::DIR_RESET[5:0];
      out_a_r       <= epc_pkg::DATA_RESET;
      out_g_r       <= epc_pkg::DATA_RESET;
      out_b_r       <= epc_pkg::DATA_RESET;
      out_f_r       <= epc_pkg::DATA_RESET;
      out_c_r       <= epc_pkg::DATA_RESET;
      out_d_r       <= epc_pkg::DATA_RESET[5:0];
      sel_stretch_r <= epc_pkg::DATA_RESET;
      sel_control_r <= epc_pkg::DATA_RESET;
      sel_base_r    <= epc_pkg::DATA_RESET;
      sel_size_r    <= epc_pkg::DATA_RESET;
      ext_addr_r    <= epc_pkg::ADDR_RESET;
      ext_wdata_r   <= epc_pkg::DATA_RESET;
      ext_write_r   <= 1'b0;
      int_mask_r    <= epc_pkg::MASK_RESET;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        epc_pkg::IDX_PORT_A_DATA: out_a_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_A_DIR:  dir_a_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_G_DATA: out_g_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_G_DIR:  dir_g_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_B_DATA: out_b_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_F_DATA: out_f_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_C_DATA: out_c_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_C_DIR:  dir_c_r <= hwdata_i[7:0];
        epc_pkg::IDX_PORT_D_DATA: out_d_r <= hwdata_i[5:0];
        epc_pkg::IDX_PORT_D_DIR:  dir_d_r <= hwdata_i[5:0];
        epc_pkg::IDX_SEL_STRETCH: sel_stretch_r <= hwdata_i[7:0];
        epc_pkg::IDX_SEL_CONTROL: sel_control_r <= hwdata_i[7:0];
        epc_pkg::IDX_SEL_BASE:    sel_base_r <= hwdata_i[7:0];
        epc_pkg::IDX_SEL_SIZE:    sel_size_r <= hwdata_i[7:0];
        epc_pkg::IDX_EXT_ADDR:    ext_addr_r <= hwdata_i[15:0];
        epc_pkg::IDX_EXT_DATA:    ext_wdata_r <= hwdata_i[7:0];
        epc_pkg::IDX_EXT_CTRL:    ext_write_r <= hwdata_i[epc_pkg::CTRL_WRITE_BIT];
        epc_pkg::IDX_INT_MASK: begin
          int_mask_r[epc_pkg::MASK_IRQ_BIT] <= hwdata_i[epc_pkg::MASK_IRQ_BIT];
          // Non-maskable mask can only be cleared, never set again
          int_mask_r[epc_pkg::MASK_NONMASKABLE_INTERRUPT_IN_BIT] <= int_mask_r[epc_pkg::MASK_NONMASKABLE_INTERRUPT_IN_BIT]
                                                & hwdata_i[epc_pkg::MASK_NONMASKABLE_INTERRUPT_IN_BIT];
        end
        default: ;
      endcase
    end
  end

  // Pending external cycle; a new start wins over the take-up clear
  assign start_req = wr_pend_r && (wr_idx_r == epc_pkg::IDX_EXT_CTRL)
                     && hwdata_i[epc_pkg::CTRL_START_BIT];
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_pend_r <= 1'b0;
    end else if (start_req) begin
      ext_pend_r <= expanded;
    end else if (cyc_nxt == epc_pkg::EPC_CYC_ADDR && cyc_r != epc_pkg::EPC_CYC_ADDR) begin
      ext_pend_r <= 1'b0;
    end
  end

  // External cycle: address phase while clock low, data phase while high
  always_comb begin
    cyc_nxt = cyc_r;
    unique case (cyc_r)
      epc_pkg::EPC_CYC_IDLE: if (e_fall && ext_pend_r) cyc_nxt = epc_pkg::EPC_CYC_ADDR;
      epc_pkg::EPC_CYC_ADDR: if (e_rise) cyc_nxt = epc_pkg::EPC_CYC_DATA;
      epc_pkg::EPC_CYC_DATA: if (e_fall) cyc_nxt = ext_pend_r ? epc_pkg::EPC_CYC_ADDR : epc_pkg::EPC_CYC_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r       <= epc_pkg::EPC_CYC_IDLE;
      ext_rdata_r <= epc_pkg::DATA_RESET;
    end else begin
      cyc_r <= cyc_nxt;
      if (cyc_r == epc_pkg::EPC_CYC_DATA && e_fall && !ext_write_r) begin
        ext_rdata_r <= pc_s;
      end
    end
  end

  // Pin drive from next values, in step with the phase clock
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      port_a_pins_o      <= epc_pkg::DATA_RESET;
      port_a_pins_oe_n_o <= 8'hFF;
      port_b_pins_o      <= epc_pkg::DATA_RESET;
      port_f_pins_o      <= epc_pkg::DATA_RESET;
      port_c_pins_o      <= epc_pkg::DATA_RESET;
      port_c_pins_oe_n_o <= 8'hFF;
      port_d_pins_o      <= epc_pkg::DATA_RESET[5:0];
      port_d_pins_oe_n_o <= 6'h3F;
      port_g_pins_o      <= epc_pkg::DATA_RESET;
      port_g_pins_oe_n_o <= 8'hFF;
      read_write_o       <= 1'b1;
    end else begin
      port_a_pins_o      <= out_a_r;
      port_a_pins_oe_n_o <= ~dir_a_r;
      port_b_pins_o      <= expanded ? ext_addr_r[15:8] : out_b_r;
      port_f_pins_o      <= expanded ? ext_addr_r[7:0] : out_f_r;
      if (expanded) begin
        port_c_pins_o      <= ext_wdata_r;
        port_c_pins_oe_n_o <= {8{!(cyc_nxt == epc_pkg::EPC_CYC_DATA && ext_write_r && e_nxt)}};
        read_write_o       <= !(cyc_nxt != epc_pkg::EPC_CYC_IDLE && ext_write_r);
      end else begin
        port_c_pins_o      <= out_c_r;
        port_c_pins_oe_n_o <= ~dir_c_r;
        read_write_o       <= 1'b1;
      end
      port_d_pins_o      <= (serial_take_i & serial_out_i) | (~serial_take_i & out_d_r);
      port_d_pins_oe_n_o <= ~((serial_take_i & serial_drive_i) | (~serial_take_i & dir_d_r));
      if (sel_control_r[epc_pkg::SEL_ENABLE_BIT]) begin
        port_g_pins_o      <= {chip_select_i, out_g_r[3:0]};
        port_g_pins_oe_n_o <= {4'h0, ~dir_g_r[3:0]};
      end else begin
        port_g_pins_o      <= out_g_r;
        port_g_pins_oe_n_o <= ~dir_g_r;
      end
    end
  end

endmodule

// *** bench/epc_props.sv ***
/* Assertions on the pin control block.
   Assumes binding to its top module. */
`timescale 1ns/1ps
module epc_props (
  input wire logic clk_sys_i, rst_n_i, hreadyout_o, hresp_o, oscillator_input_i, buffered_osc_out_o,
  input wire logic e_clock_o, inverted_bus_strobe_o, reset_pin_oe_n_o, clock_monitor_fail_i,
  input wire logic watchdog_timer_fail_i, irq_n_i, nonmaskable_interrupt_in_n_i, irq_req_o, nmi_req_o,
  input wire logic instruction_start_out_o, instruction_start_oe_n_o,
  input wire logic [1:0] mode_o,
  input wire logic [7:0] port_c_pins_oe_n_o
);
  logic [3:0] up_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) up_r <= 4'h0;
    else if (!(&up_r)) up_r <= up_r + 4'h1;
  end
  chk_strobe_inverse: assert property (inverted_bus_strobe_o == !e_clock_o)
    else $error("strobe not inverse");
  chk_fail_pulls: assert property (&up_r && (clock_monitor_fail_i || watchdog_timer_fail_i) |=>
    !reset_pin_oe_n_o) else $error("reset pin not pulled");
  chk_high_phase: assert property ($rose(e_clock_o) |-> e_clock_o [*8])
    else $error("high phase short");
  chk_osc_copy: assert property (&up_r |-> buffered_osc_out_o == $past(oscillator_input_i, 3))
    else $error("oscillator copy wrong");
  chk_irq_idle: assert property (irq_n_i [*4] |-> !irq_req_o)
    else $error("request, pin high");
  chk_nmi_idle: assert property (nonmaskable_interrupt_in_n_i [*4] |-> !nmi_req_o)
    else $error("second request, pin high");
  chk_start_mark: assert property (!instruction_start_oe_n_o |-> !instruction_start_out_o
    ##1 instruction_start_oe_n_o) else $error("start mark wrong");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not okay");
  chk_data_low: assert property ($fell(e_clock_o) && mode_o == 2'h3 |-> ##1 port_c_pins_oe_n_o == 8'hff)
    else $error("data driven in low phase");
endmodule
bind epc_top epc_props u_props (.*);

// *** bench/epc_far_mem.sv ***
/* Memory on the expanded bus.
   Assumes address on port F, data on port C. */
`timescale 1ns/1ps
module epc_far_mem (
  // Bus pins
  input  wire logic       clk_sys_i,
  input  wire logic       e_i,
  input  wire logic       rw_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] addr_lo_i,
  input  wire logic [7:0] data_i,
  // Driven back
  output logic [7:0]      data_o,
  output logic            wait_o
);
  logic [7:0] mem [256];
  initial data_o = 8'h00;
  // Stretch every cycle while slow_i is high
  assign wait_o = slow_i;
  // Write, read, or toggle when released
  always @(posedge clk_sys_i) begin
    if (e_i && !rw_i) mem[addr_lo_i] <= data_i;
    data_o <= (e_i && rw_i) ? mem[addr_lo_i] : ~data_o;
  end
endmodule

// *** bench/epc_top_bench.sv ***
/* Bench for the pin control block.
   Assumes expanded mode and a far memory. */
`timescale 1ns/1ps
module epc_top_bench;
  logic clk_sys_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, oscillator_input_i = 0, wait_i, far_slow = 0;
  logic clock_monitor_fail_i = 0, watchdog_timer_fail_i = 0, irq_n_i = 1, nonmaskable_interrupt_in_n_i = 1;
  logic mode_select_first_i = 1, mode_select_second_i = 1, instr_start_i = 0, hreadyout_o, hresp_o;
  logic buffered_osc_out_o, e_clock_o, inverted_bus_strobe_o, read_write_o, reset_pin_oe_n_o, irq_req_o;
  logic nmi_req_o, instruction_start_out_o, instruction_start_oe_n_o, e_prev = 0, rw_low;
  logic [1:0] htrans_i = 0, mode_o;
  logic [2:0] hsize_i = 3'h2;
  logic [3:0] chip_select_i = 4'ha;
  logic [5:0] port_d_pins_i = 6'h2a, port_d_pins_o, port_d_pins_oe_n_o, serial_take_i = 0;
  logic [5:0] serial_out_i = 6'h15, serial_drive_i = 6'h3f;
  logic [7:0] port_a_pins_i = 8'h5a, port_a_pins_o, port_a_pins_oe_n_o, port_b_pins_o, port_f_pins_o;
  logic [7:0] port_c_pins_i, port_c_pins_o, port_c_pins_oe_n_o, input_port_e_data_i = 8'hc3, far_c;
  logic [7:0] port_g_pins_i = 8'h00, port_g_pins_o, port_g_pins_oe_n_o;
  logic [15:0] haddr_i = 0;
  logic [31:0] hwdata_i = 0, hrdata_o, q;
  int errors = 0, checks_done = 0, cyc = 0, run = 0, hi_len, lo_len;
  wire hready_i = hreadyout_o;
  // Data bus wire level
  assign port_c_pins_i = (port_c_pins_o & ~port_c_pins_oe_n_o) | (far_c & port_c_pins_oe_n_o);
  epc_top u_dut (.*);
  epc_far_mem u_far (.clk_sys_i(clk_sys_i), .e_i(e_clock_o), .rw_i(read_write_o), .slow_i(far_slow),
    .addr_lo_i(port_f_pins_o), .data_i(port_c_pins_i), .data_o(far_c), .wait_o(wait_i));
  always #50 clk_sys_i = ~clk_sys_i;
  always #400 oscillator_input_i = ~oscillator_input_i;
  // Run lengths, rise direction, hang limit
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin errors++; results(); end
    if (e_clock_o !== e_prev) begin
      if (e_prev) hi_len = run;
      else begin lo_len = run; if (read_write_o === 1'b0) rw_low = 1; end
      run = 1;
    end else run++;
    e_prev = e_clock_o;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin errors++; $display("unexpected %0t: %h not %h", $time, s, e); end
  endtask
  task results();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One word transfer
  task bus(input logic w, input logic [13:0] i, input logic [31:0] d);
    hsel_i <= 1; htrans_i <= 2'h2; hwrite_i <= w; haddr_i <= {i, 2'h0};
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 0; htrans_i <= 2'h0; hwdata_i <= d;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task idle();
    do bus(0, epc_pkg::IDX_STATUS, 0); while (q[0] !== 1'b0);
  endtask
  // Directions, inputs, unmapped, serial, chip selects
  task t_ports();
    bus(1, epc_pkg::IDX_PORT_A_DIR, 32'h0000_00a5); bus(0, epc_pkg::IDX_PORT_A_DIR, 0);
    chk(q, 32'h0000_00a5); chk(port_a_pins_oe_n_o, 8'h5a);
    bus(0, epc_pkg::IDX_PORT_D_DATA, 0); chk(q, 32'h0000_002a);
    bus(0, epc_pkg::IDX_PORT_E_DATA, 0); chk(q, 32'h0000_00c3);
    bus(1, 14'h0000, 32'h0000_0077); bus(0, 14'h0000, 0); chk(q, 0);
    serial_take_i <= 6'h3f; bus(1, epc_pkg::IDX_SEL_CONTROL, 32'h0000_0004); repeat (3) @(posedge clk_sys_i);
    chk({port_d_pins_oe_n_o, port_d_pins_o}, 12'h015);
    chk({port_g_pins_oe_n_o[7:4], port_g_pins_o[7:4]}, 8'h0a);
  endtask
  // External write, then read back
  task t_ext(input logic slow, input int hi);
    far_slow <= slow; rw_low = 0;
    bus(1, epc_pkg::IDX_EXT_ADDR, 32'h0000_12ab); bus(1, epc_pkg::IDX_EXT_DATA, 32'h0000_005e);
    bus(1, epc_pkg::IDX_EXT_CTRL, 32'h0000_0003); idle();
    chk({port_b_pins_o, port_f_pins_o}, 16'h12ab);
    chk({rw_low, u_far.mem[8'hab]}, 9'h15e);
    bus(1, epc_pkg::IDX_EXT_CTRL, 32'h0000_0001); idle(); bus(0, epc_pkg::IDX_EXT_DATA, 0);
    chk(q, 32'h0000_005e);
    chk({hi_len[15:0], lo_len[15:0]}, {hi[15:0], 16'd16});
  endtask
  // Interrupts, failure and start pulses
  task t_irq();
    irq_n_i <= 0; nonmaskable_interrupt_in_n_i <= 0; repeat (5) @(posedge clk_sys_i);
    chk({irq_req_o, nmi_req_o}, 0);
    bus(1, epc_pkg::IDX_INT_MASK, 0); repeat (5) @(posedge clk_sys_i);
    chk({irq_req_o, nmi_req_o}, 2'h3);
    irq_n_i <= 1; nonmaskable_interrupt_in_n_i <= 1; watchdog_timer_fail_i <= 1; instr_start_i <= 1;
    @(posedge clk_sys_i); watchdog_timer_fail_i <= 0; instr_start_i <= 0; clock_monitor_fail_i <= 1; #1;
    chk({reset_pin_oe_n_o, instruction_start_oe_n_o}, 0);
    @(posedge clk_sys_i); clock_monitor_fail_i <= 0; #1;
    chk({reset_pin_oe_n_o, instruction_start_oe_n_o}, 1);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    chk({e_clock_o, inverted_bus_strobe_o, read_write_o, port_a_pins_oe_n_o}, 11'h3ff);
    rst_n_i <= 1; repeat (8) @(posedge clk_sys_i);
    chk(mode_o, 2'h3);
    t_ports(); t_ext(0, 16); t_ext(1, 32); t_irq();
    results();
  end
endmodule
